//--- design/condition_flags_register.sv
`default_nettype none
module condition_flags_register
  import flags_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  // Datapath update
  input wire logic alu_valid,
  input wire flags_pkg::alu_op_t alu_op,
  input wire flags_pkg::size_t alu_size,
  input wire logic [31:0] alu_src,
  input wire logic [31:0] alu_dst,
  input wire logic [31:0] alu_logic_res,
  input wire logic alu_shift_out,
  // Flag transfer instructions
  input wire flags_pkg::flag_instr_t flag_instr,
  input wire logic [7:0] flag_imm,
  // Bit manipulation through the carry accumulator
  input wire flags_pkg::bit_op_t bit_op,
  input wire logic bit_in,
  input wire logic bit_invert,
  // Exception and interrupt
  input wire logic exc_start,
  input wire logic irq_req,
  input wire logic nmi_req,
  // Branch and register file side
  input wire flags_pkg::cond_t branch_cond_sel,
  input wire logic greg_we,
  input wire logic [2:0] greg_sel,
  input wire logic [31:0] greg_wdata,
  input wire logic [2:0] greg_rsel,
  output logic [7:0] condition_flags,
  output logic [7:0] extended_control,
  output logic [7:0] store_data,
  output logic bit_out,
  output logic branch_taken,
  output logic irq_accept,
  output logic nmi_accept,
  output logic [31:0] stack_pointer,
  output logic [31:0] alu_result,
  output logic [31:0] greg_rdata
);
  import flags_pkg::*;

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] ext_r;
  logic [7:0] store_r;
  logic bit_out_r;
  logic taken_r;
  logic irq_acc_r;
  logic nmi_acc_r;
  logic [31:0] res_r;
  logic [31:0] rdata_r;
  logic [31:0] gregs_r [NUM_GREGS];

  wire [31:0] res_w;
  wire half_w, neg_w, zero_w, ovf_w, carry_w, sets_half_w, sets_vc_w;
  wire taken_w;

  flag_alu u_alu (
    .op(alu_op),
    .size(alu_size),
    .src(alu_src),
    .dst(alu_dst),
    .carry_in(flags_r[POS_CARRY]),
    .zero_in(flags_r[POS_ZERO]),
    .shift_out(alu_shift_out),
    .logic_res(alu_logic_res),
    .result(res_w),
    .half(half_w),
    .neg(neg_w),
    .zero(zero_w),
    .ovf(ovf_w),
    .carry(carry_w),
    .sets_half(sets_half_w),
    .sets_vc(sets_vc_w)
  );

  branch_cond u_cond (
    .cond(branch_cond_sel),
    .flags(flags_r),
    .taken(taken_w)
  );

  wire alu_upd = alu_valid && (alu_op != OP_NONE);
  wire bit_src = bit_in ^ bit_invert;
  wire c_now = flags_r[POS_CARRY];

  // Carry accumulator next value for bit instructions
  wire bit_carry_upd = (bit_op == BIT_LOAD) || (bit_op == BIT_AND) ||
                       (bit_op == BIT_OR) || (bit_op == BIT_XOR);
  wire bit_carry_nxt = (bit_op == BIT_LOAD) ? bit_src :
                       (bit_op == BIT_AND) ? (c_now & bit_src) :
                       (bit_op == BIT_OR) ? (c_now | bit_src) :
                       (c_now ^ bit_src);

  // Arithmetic flag merge; undefined effects keep the old value
  wire [7:0] alu_flags = {
    flags_r[POS_MASK],
    flags_r[POS_UMASK],
    sets_half_w ? half_w : flags_r[POS_HALF],
    flags_r[POS_USER],
    neg_w,
    zero_w,
    sets_vc_w ? ovf_w : flags_r[POS_OVF],
    sets_vc_w ? carry_w : flags_r[POS_CARRY]
  };

  // Priority: transfer instruction, then datapath, then bit op; exception mask last
  always_comb begin
    flags_nxt = flags_r;
    case (flag_instr)
      FI_LOAD: flags_nxt = flag_imm;
      FI_AND: flags_nxt = flags_r & flag_imm;
      FI_OR: flags_nxt = flags_r | flag_imm;
      FI_XOR: flags_nxt = flags_r ^ flag_imm;
      FI_STORE: flags_nxt = flags_r;
      FI_NONE: begin
        if (alu_upd) begin
          flags_nxt = alu_flags;
        end else if (bit_carry_upd) begin
          flags_nxt[POS_CARRY] = bit_carry_nxt;
        end
      end
      default: flags_nxt = flags_r;
    endcase
    if (exc_start) begin
      flags_nxt[POS_MASK] = 1'b1;
    end
  end

  // Only the mask bit is defined by reset; zeros elsewhere are a convenience
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= FLAGS_RST;
      ext_r <= EXT_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      store_r <= 8'h00;
      bit_out_r <= 1'b0;
      taken_r <= 1'b0;
      irq_acc_r <= 1'b0;
      nmi_acc_r <= 1'b0;
      res_r <= 32'h0;
    end else begin
      if (flag_instr == FI_STORE) begin
        store_r <= flags_r;
      end
      if (bit_op == BIT_STORE) begin
        bit_out_r <= c_now ^ bit_invert;
      end
      taken_r <= taken_w;
      irq_acc_r <= irq_req && !flags_r[POS_MASK];
      nmi_acc_r <= nmi_req;
      if (alu_upd) begin
        res_r <= res_w;
      end
    end
  end

  // General registers have no reset: their contents are undefined at power-up
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GREGS; gi++) begin : g_greg
      always_ff @(posedge clk) begin
        if (greg_we && (greg_sel == 3'(gi))) begin
          gregs_r[gi] <= greg_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= gregs_r[greg_rsel];
    end
  end

  assign condition_flags = flags_r;
  assign extended_control = ext_r;
  assign store_data = store_r;
  assign bit_out = bit_out_r;
  assign branch_taken = taken_r;
  assign irq_accept = irq_acc_r;
  assign nmi_accept = nmi_acc_r;
  assign stack_pointer = gregs_r[SP_INDEX];
  assign alu_result = res_r;
  assign greg_rdata = rdata_r;
endmodule
`default_nettype wire

//--- include/flags_pkg.sv
`default_nettype none
package flags_pkg;
  localparam int unsigned FLAG_W = 8;
  // Bit positions inside the condition flags register
  localparam int unsigned POS_MASK = 7;
  localparam int unsigned POS_UMASK = 6;
  localparam int unsigned POS_HALF = 5;
  localparam int unsigned POS_USER = 4;
  localparam int unsigned POS_NEG = 3;
  localparam int unsigned POS_ZERO = 2;
  localparam int unsigned POS_OVF = 1;
  localparam int unsigned POS_CARRY = 0;
  // Reset values; only the mask bits are defined, the other flag bits read as zero here and extended control resets to 8'h7f
  localparam logic [7:0] FLAGS_RST = 8'h80;
  localparam logic [7:0] EXT_RST = 8'h7f;
  localparam int unsigned EXT_POS_TRACE = 7;
  localparam logic [2:0] EXT_MASK_ALL = 3'h7;
  // Half-carry tap points per operand size
  localparam int unsigned HALF_BIT_B = 3;
  localparam int unsigned HALF_BIT_W = 11;
  localparam int unsigned HALF_BIT_L = 27;
  localparam int unsigned NUM_GREGS = 8;
  localparam int unsigned SP_INDEX = 7;
  localparam int unsigned DATA_W = 32;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } size_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD = 4'h1,
    OP_ADDX = 4'h2,
    OP_SUB = 4'h3,
    OP_SUBX = 4'h4,
    OP_CMP = 4'h5,
    OP_NEG = 4'h6,
    OP_LOGIC = 4'h7,
    OP_SHIFT = 4'h8,
    OP_MOVE = 4'h9
  } alu_op_t;

  typedef enum logic [2:0] {
    FI_NONE = 3'h0,
    FI_LOAD = 3'h1,
    FI_STORE = 3'h2,
    FI_AND = 3'h3,
    FI_OR = 3'h4,
    FI_XOR = 3'h5
  } flag_instr_t;

  typedef enum logic [2:0] {
    BIT_NONE = 3'h0,
    BIT_LOAD = 3'h1,
    BIT_AND = 3'h2,
    BIT_OR = 3'h3,
    BIT_XOR = 3'h4,
    BIT_STORE = 3'h5
  } bit_op_t;

  typedef enum logic [3:0] {
    CC_ALWAYS = 4'h0, CC_NEVER = 4'h1, CC_HI = 4'h2, CC_LS = 4'h3,
    CC_CC = 4'h4, CC_CS = 4'h5, CC_NE = 4'h6, CC_EQ = 4'h7,
    CC_VC = 4'h8, CC_VS = 4'h9, CC_PL = 4'ha, CC_MI = 4'hb,
    CC_GE = 4'hc, CC_LT = 4'hd, CC_GT = 4'he, CC_LE = 4'hf
  } cond_t;

  // Sign bit position for a given operand size
  function automatic logic [4:0] msb_pos(input size_t sz);
    case (sz)
      SZ_BYTE: msb_pos = 5'h07;
      SZ_WORD: msb_pos = 5'h0f;
      default: msb_pos = 5'h1f;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- design/flag_alu.sv
`default_nettype none
module flag_alu
  import flags_pkg::*;
(
  input wire flags_pkg::alu_op_t op,
  input wire flags_pkg::size_t size,
  input wire logic [31:0] src,
  input wire logic [31:0] dst,
  input wire logic carry_in,
  input wire logic zero_in,
  input wire logic shift_out,
  input wire logic [31:0] logic_res,
  output logic [31:0] result,
  output logic half,
  output logic neg,
  output logic zero,
  output logic ovf,
  output logic carry,
  output logic sets_half,
  output logic sets_vc
);
  import flags_pkg::*;

  wire is_sub = (op == OP_SUB) || (op == OP_SUBX) || (op == OP_CMP) || (op == OP_NEG);
  wire use_x = (op == OP_ADDX) || (op == OP_SUBX);
  wire [31:0] a = (op == OP_NEG) ? 32'h0 : dst;
  wire [31:0] b_raw = is_sub ? ~src : src;
  // Subtraction as a + ~b + 1, with the extend carry folded in
  wire cin = is_sub ? ~(use_x & carry_in) : (use_x & carry_in);
  wire [32:0] sum = {1'b0, a} + {1'b0, b_raw} + {32'h0, cin};
  wire [31:0] cvec = a ^ b_raw ^ sum[31:0];
  wire [4:0] msb = msb_pos(size);
  wire [4:0] hb = (size == SZ_BYTE) ? 5'(HALF_BIT_B) :
                  (size == SZ_WORD) ? 5'(HALF_BIT_W) : 5'(HALF_BIT_L);
  wire carry_at_msb = (msb == 5'h1f) ? sum[32] : cvec[msb + 5'h01];
  wire is_arith = (op != OP_NONE) && (op != OP_LOGIC) && (op != OP_SHIFT) &&
                  (op != OP_MOVE);
  wire [31:0] res_w = is_arith ? sum[31:0] : logic_res;
  wire [31:0] masked = (size == SZ_BYTE) ? {24'h0, res_w[7:0]} :
                       (size == SZ_WORD) ? {16'h0, res_w[15:0]} : res_w;
  wire sa = a[msb];
  wire sb = b_raw[msb];
  wire sr = res_w[msb];
  wire zero_now = (masked == 32'h0);

  assign result = masked;
  assign half = is_sub ? ~cvec[hb + 5'h01] : cvec[hb + 5'h01];
  assign neg = sr;
  // Extended ops keep zero only if it was already set
  assign zero = use_x ? (zero_now & zero_in) : zero_now;
  assign ovf = is_arith ? ((sa == sb) && (sr != sa)) : 1'b0;
  // Logic ops define no carry effect, so the old carry passes through
  assign carry = is_arith ? (is_sub ? ~carry_at_msb : carry_at_msb) :
                 (op == OP_SHIFT) ? shift_out : carry_in;
  assign sets_half = is_arith && !(size == SZ_BYTE ? 1'b0 : use_x);
  assign sets_vc = is_arith || (op == OP_SHIFT) || (op == OP_LOGIC);
endmodule
`default_nettype wire

//--- design/branch_cond.sv
`default_nettype none
module branch_cond
  import flags_pkg::*;
(
  input wire flags_pkg::cond_t cond,
  input wire logic [7:0] flags,
  output logic taken
);
  import flags_pkg::*;

  wire n = flags[POS_NEG];
  wire z = flags[POS_ZERO];
  wire v = flags[POS_OVF];
  wire c = flags[POS_CARRY];

  always_comb begin
    case (cond)
      CC_ALWAYS: taken = 1'b1;
      CC_NEVER: taken = 1'b0;
      CC_HI: taken = !(c | z);
      CC_LS: taken = c | z;
      CC_CC: taken = !c;
      CC_CS: taken = c;
      CC_NE: taken = !z;
      CC_EQ: taken = z;
      CC_VC: taken = !v;
      CC_VS: taken = v;
      CC_PL: taken = !n;
      CC_MI: taken = n;
      CC_GE: taken = !(n ^ v);
      CC_LT: taken = n ^ v;
      CC_GT: taken = !(z | (n ^ v));
      CC_LE: taken = z | (n ^ v);
      default: taken = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- dv/condition_flags_properties.sv
`default_nettype none
module condition_flags_properties
  import flags_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire flags_pkg::flag_instr_t flag_instr,
  input wire logic [7:0] flag_imm,
  input wire logic alu_valid,
  input wire flags_pkg::bit_op_t bit_op,
  input wire logic exc_start,
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic [7:0] condition_flags,
  input wire logic [7:0] extended_control,
  input wire logic [7:0] store_data,
  input wire logic irq_accept,
  input wire logic nmi_accept
);
  import flags_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_quiet;
    flag_instr == FI_NONE && !alu_valid && bit_op == BIT_NONE && !exc_start;
  endsequence
  sequence s_plain(flag_instr_t k);
    flag_instr == k && !exc_start;
  endsequence
  a_load_copies: assert property (
    s_plain(FI_LOAD) |=> condition_flags == $past(flag_imm))
    else $error("flag load not copied");
  a_xor_toggles: assert property (s_plain(FI_XOR) |=>
    condition_flags == ($past(condition_flags) ^ $past(flag_imm)))
    else $error("flag xor wrong");
  a_store_snap: assert property (s_plain(FI_STORE) |=>
    store_data == $past(condition_flags) && $stable(condition_flags))
    else $error("flag store wrong");
  a_exc_mask: assert property (exc_start |=> condition_flags[POS_MASK])
    else $error("mask not forced");
  a_nmi_taken: assert property (nmi_req |=> nmi_accept)
    else $error("nmi refused");
  a_irq_blocked: assert property (
    irq_req && condition_flags[POS_MASK] |=> !irq_accept)
    else $error("masked irq accepted");
  a_irq_open: assert property (irq_req && !condition_flags[POS_MASK] |=> irq_accept)
    else $error("open irq refused");
  a_ext_fixed: assert property (extended_control == EXT_RST)
    else $error("extended control changed");
  a_idle_keeps: assert property (s_quiet |=> $stable(condition_flags))
    else $error("flags moved while idle");
endmodule
bind condition_flags_register condition_flags_properties u_props (.clk(clk), .arst_n(arst_n),
  .flag_instr(flag_instr), .flag_imm(flag_imm), .alu_valid(alu_valid), .bit_op(bit_op),
  .exc_start(exc_start), .irq_req(irq_req), .nmi_req(nmi_req),
  .condition_flags(condition_flags), .extended_control(extended_control),
  .store_data(store_data), .irq_accept(irq_accept), .nmi_accept(nmi_accept));
`default_nettype wire

//--- dv/tb_condition_flags_register.sv
`default_nettype none
module tb_condition_flags_register;
  timeunit 1ns;
  timeprecision 1ps;
  import flags_pkg::*;
  typedef struct packed {
    logic alu_valid; alu_op_t alu_op; size_t alu_size; logic [31:0] alu_src, alu_dst, alu_lres;
    logic alu_sout; flag_instr_t flag_instr; logic [7:0] flag_imm; bit_op_t bit_op;
    logic bit_in, bit_inv, exc, irq, nmi; cond_t cond; logic gwe; logic [2:0] gsel;
    logic [31:0] gwd; logic [2:0] grs;
  } stim_t;
  typedef struct {int due; int sel; logic [31:0] v;} note_t;
  logic clk, arst_n, bit_out, branch_taken, irq_accept, nmi_accept, c, bo;
  logic [7:0] condition_flags, extended_control, store_data, fl;
  logic [31:0] stack_pointer, alu_result, greg_rdata, v;
  stim_t s, n;
  note_t q[$];
  note_t nt;
  int cyc, mismatches, samples_checked, seed, w;
  flag_instr_t k;
  bit_op_t bk;
  alu_op_t ops [6] = '{OP_ADD, OP_SUB, OP_CMP, OP_NEG, OP_ADDX, OP_SUBX};
  condition_flags_register dut (.clk(clk), .arst_n(arst_n), .alu_valid(s.alu_valid),
    .alu_op(s.alu_op), .alu_size(s.alu_size), .alu_src(s.alu_src), .alu_dst(s.alu_dst),
    .alu_logic_res(s.alu_lres), .alu_shift_out(s.alu_sout), .flag_instr(s.flag_instr),
    .flag_imm(s.flag_imm), .bit_op(s.bit_op), .bit_in(s.bit_in), .bit_invert(s.bit_inv),
    .exc_start(s.exc), .irq_req(s.irq), .nmi_req(s.nmi), .branch_cond_sel(s.cond),
    .greg_we(s.gwe), .greg_sel(s.gsel), .greg_wdata(s.gwd), .greg_rsel(s.grs),
    .condition_flags(condition_flags), .extended_control(extended_control),
    .store_data(store_data), .bit_out(bit_out), .branch_taken(branch_taken),
    .irq_accept(irq_accept), .nmi_accept(nmi_accept), .stack_pointer(stack_pointer),
    .alu_result(alu_result), .greg_rdata(greg_rdata));
  function automatic int wid(input size_t sz);
    return (sz == SZ_BYTE) ? 8 : (sz == SZ_WORD) ? 16 : 32;
  endfunction
  function automatic logic [7:0] arith(input alu_op_t op, input size_t sz,
      input logic [31:0] d, input logic [31:0] s0, input logic [7:0] f);
    logic [33:0] m, hm, a, b, r;
    logic e, cx, sub, hs, cs, ov, z;
    int ww;
    ww = wid(sz);
    m = (34'h1 << ww) - 34'h1;
    hm = (34'h1 << (ww - 4)) - 34'h1;
    a = (op == OP_NEG) ? 34'h0 : {2'h0, d} & m;
    b = {2'h0, s0} & m;
    e = op == OP_ADDX || op == OP_SUBX;
    cx = e && f[0];
    sub = op != OP_ADD && op != OP_ADDX;
    r = sub ? a - b - 34'(cx) : a + b + 34'(cx);
    hs = sub ? ((b & hm) + 34'(cx) > (a & hm)) : ((a & hm) + (b & hm) + 34'(cx) > hm);
    cs = sub ? (b + 34'(cx) > a) : (r > m);
    r = r & m;
    ov = (sub ? a[ww-1] != b[ww-1] : a[ww-1] == b[ww-1]) && r[ww-1] != a[ww-1];
    z = r == 34'h0 && (!e || f[2]);
    return {f[7:6], hs, f[4], r[ww-1], z, ov, cs};
  endfunction
  function automatic logic taken(input int cc, input logic [7:0] f);
    logic [7:0] tv;
    tv = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
    return !(tv[cc/2] ^ cc[0]);
  endfunction
  function automatic logic [31:0] pick(input int sel);
    case (sel)
      0: return 32'(condition_flags);
      1: return 32'(store_data);
      2: return 32'(bit_out);
      3: return alu_result;
      4: return 32'({irq_accept, nmi_accept});
      5: return 32'(branch_taken);
      6: return stack_pointer;
      default: return greg_rdata;
    endcase
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Inputs change once per edge; shadow copy cleared so idle is the default
  task automatic go();
    @(posedge clk);
    s <= n;
    n = '0;
  endtask
  // Result lands after the next capture edge, seen at the negedge after it
  task automatic note(input int sel, input logic [31:0] ev);
    q.push_back('{cyc + 2, sel, ev});
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial forever begin
    @(negedge clk);
    cyc++;
    while (q.size() > 0 && q[0].due == cyc) begin
      nt = q.pop_front();
      cmp(pick(nt.sel), nt.v);
    end
  end
  initial begin
    #(50 * 3000);
    mismatches++;
    wrap_up();
  end
  initial begin
    seed = 2;
    s = '0;
    n = '0;
    arst_n = 1'b0;
    repeat (20) @(posedge clk);
    cmp(32'(condition_flags[POS_MASK]), 32'h1);
    cmp(32'(extended_control), 32'h7f);
    arst_n <= 1'b1;
    // Stack pointer set first, before any other request
    n.gwe = 1'b1;
    n.gsel = 3'h7;
    n.gwd = $random(seed);
    v = n.gwd;
    go();
    note(6, v);
    fl = 8'h80;
    for (int i = 0; i < 15; i++) begin
      k = flag_instr_t'(i % 5 + 1);
      n.flag_instr = k;
      n.flag_imm = 8'($random(seed));
      case (k)
        FI_LOAD: fl = n.flag_imm;
        FI_AND: fl &= n.flag_imm;
        FI_OR: fl |= n.flag_imm;
        FI_XOR: fl ^= n.flag_imm;
        default: ;
      endcase
      go();
      note(0, 32'(fl));
      if (k == FI_STORE) note(1, 32'(fl));
    end
    // Exception wins over a same-cycle clear of every bit
    n.flag_instr = FI_AND;
    n.exc = 1'b1;
    fl = 8'h80;
    go();
    note(0, 32'(fl));
    $display("test flag transfer done");
    for (int i = 0; i < 36; i++) begin
      n.alu_valid = 1'b1;
      n.alu_op = ops[i%6];
      n.alu_size = (i % 6 > 3) ? SZ_BYTE : size_t'((i / 6) % 3);
      n.alu_src = $random(seed);
      n.alu_dst = (i % 7 == 0) ? n.alu_src : $random(seed);
      v = (n.alu_op == OP_NEG) ? 32'h0 - n.alu_src :
          (n.alu_op == OP_ADD) ? n.alu_dst + n.alu_src : n.alu_dst - n.alu_src;
      c = n.alu_size == SZ_LONG && n.alu_op != OP_CMP;
      fl = arith(n.alu_op, n.alu_size, n.alu_dst, n.alu_src, fl);
      go();
      note(0, 32'(fl));
      if (c) note(3, v);
    end
    for (int i = 0; i < 9; i++) begin
      n.alu_valid = 1'b1;
      n.alu_op = (i % 3 == 0) ? OP_SHIFT : (i % 3 == 1) ? OP_LOGIC : OP_MOVE;
      n.alu_size = size_t'((i / 3) % 3);
      n.alu_lres = (i == 4) ? 32'h0 : $random(seed);
      n.alu_sout = 1'($random(seed));
      w = wid(n.alu_size);
      // Move keeps V and C; logic keeps C; shift takes the shifted-out bit
      fl = {fl[7:4], n.alu_lres[w-1], (n.alu_lres << (32 - w)) == 32'h0,
            (n.alu_op == OP_MOVE) && fl[1], ((n.alu_op == OP_SHIFT) ? n.alu_sout : fl[0])};
      go();
      note(0, 32'(fl));
    end
    $display("test datapath flags done");
    for (int i = 0; i < 15; i++) begin
      bk = bit_op_t'(i % 5 + 1);
      n.bit_op = bk;
      n.bit_in = 1'($random(seed));
      n.bit_inv = 1'($random(seed));
      c = n.bit_in ^ n.bit_inv;
      bo = fl[0] ^ n.bit_inv;
      case (bk)
        BIT_LOAD: fl[0] = c;
        BIT_AND: fl[0] &= c;
        BIT_OR: fl[0] |= c;
        BIT_XOR: fl[0] ^= c;
        default: ;
      endcase
      go();
      note(0, 32'(fl));
      if (bk == BIT_STORE) note(2, 32'(bo));
    end
    $display("test bit accumulator done");
    for (int i = 0; i < 6; i++) begin
      n.flag_instr = FI_LOAD;
      n.flag_imm = {i[0], 7'($random(seed))};
      fl = n.flag_imm;
      go();
      n.irq = 1'b1;
      n.nmi = i[1];
      go();
      note(4, 32'({!fl[7], i[1]}));
      for (int cc = 0; cc < 16; cc++) begin
        n.cond = cond_t'(cc);
        go();
        note(5, 32'(taken(cc, fl)));
      end
    end
    $display("test interrupt and branch done");
    v = $random(seed);
    n.gwe = 1'b1;
    n.gsel = 3'h7;
    n.gwd = v;
    go();
    note(6, v);
    n.grs = 3'h7;
    go();
    note(7, v);
    repeat (4) @(posedge clk);
    $display("test stack pointer done");
    wrap_up();
  end
endmodule
`default_nettype wire
